//--- tb_top.sv
/*
 Self-checking bench for the baud clock generator core.
 Assumes the far-side clock model and the package are compiled first.
*/
`default_nettype none
module tb_top
    import ubcg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk;
    logic rst_n;
    ubcg_cfg_t cfg;
    logic lk_start;
    logic [7:0] lk_n;
    logic lk_drv;
    logic lk_busy;
    logic pin_o;
    logic pin_oe;
    wire logic pin_wire;
    ubcg_ticks_t ticks_q;
    logic framing_q;
    logic [4:0] spb_q;
    ubcg_clock_mode_t mode_q;
    logic pin_prev;
    logic chg_prev;
    int failures;
    int compares;
    int n_smp;
    int n_bit;
    int n_chg;
    int n_dsm;
    int n_rise;
    int n_mis;

    // The device drives the pin only while its enable is high.
    assign pin_wire = pin_oe ? pin_o : lk_drv;

    ubcg_core i_dut (
        .clk(clk),
        .rst_n(rst_n),
        .cfg(cfg),
        .transfer_clock_pin_i(pin_wire),
        .transfer_clock_pin_o(pin_o),
        .transfer_clock_pin_oe(pin_oe),
        .ticks_q(ticks_q),
        .framing_enable_q(framing_q),
        .samples_per_bit_q(spb_q),
        .clock_mode_q(mode_q)
    );

    ubcg_link_clk_model i_link (
        .start(lk_start),
        .n_pulses(lk_n),
        .pin(lk_drv),
        .busy(lk_busy)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Event counters, sampled mid-cycle where outputs are settled
    // ------------------------------------------------------------------
    always @(negedge clk) begin
        if (ticks_q.sample_tick === 1'b1) n_smp++;
        if (ticks_q.bit_tick === 1'b1) n_bit++;
        if (ticks_q.data_change === 1'b1) n_chg++;
        if (ticks_q.data_sample === 1'b1) n_dsm++;
        if (pin_o === 1'b1 && pin_prev === 1'b0) n_rise++;
        // A driven pin rises exactly one cycle after each data change tick.
        if (pin_oe === 1'b1 &&
            ((pin_o === 1'b1 && pin_prev === 1'b0) != (chg_prev === 1'b1))) n_mis++;
        pin_prev = pin_o;
        chg_prev = ticks_q.data_change;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic clear_counts();
        n_smp = 0;
        n_bit = 0;
        n_chg = 0;
        n_dsm = 0;
        n_rise = 0;
        n_mis = 0;
    endtask

    task automatic set_cfg(input ubcg_port_mode_t pm, input logic dbl,
                           input logic [11:0] per, input logic signed [3:0] sc);
        @(posedge clk);
        cfg <= '{port_mode: pm, double_speed_select: dbl, baud_period_setting: per,
                 baud_scale_exponent: sc};
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_modes();
        ubcg_port_mode_t pm[6] = '{UBCG_PM_ASYNC, UBCG_PM_ASYNC, UBCG_PM_SYNC_MASTER,
            UBCG_PM_SYNC_SLAVE, UBCG_PM_SPI_MASTER, ubcg_port_mode_t'(4'h3)};
        ubcg_clock_mode_t cm[6] = '{UBCG_CM_ASYNC_NORMAL, UBCG_CM_ASYNC_DOUBLE,
            UBCG_CM_SYNC_MASTER, UBCG_CM_SYNC_SLAVE, UBCG_CM_SPI_MASTER, UBCG_CM_ASYNC_NORMAL};
        logic [4:0] spb[6] = '{UBCG_SAMPLES_NORMAL, UBCG_SAMPLES_DOUBLE, UBCG_SAMPLES_NONE,
            UBCG_SAMPLES_NONE, UBCG_SAMPLES_NONE, UBCG_SAMPLES_NORMAL};
        logic [5:0] dbl = 6'h02;
        logic [5:0] fr = 6'h2f;
        logic [5:0] oe = 6'h14;
        for (int i = 0; i < 6; i++) begin
            set_cfg(pm[i], dbl[i], 12'h000, 4'h0);
            repeat (3) @(posedge clk);
            // Read mid-cycle, away from the edge that updates the outputs.
            @(negedge clk);
            chk("clock_mode", cm[i], mode_q);
            chk("samples_per_bit", spb[i], spb_q);
            chk("framing_enable", fr[i], framing_q);
            chk("pin_oe", oe[i], pin_oe);
        end
        $display("test_modes done");
    endtask

    // A negative bit or change expectation skips that count.
    task automatic rate(input ubcg_port_mode_t pm, input logic dbl, input logic [11:0] per,
                        input logic signed [3:0] sc, input int settle, input int win,
                        input int e_smp, input int e_bit, input int e_chg);
        set_cfg(pm, dbl, per, sc);
        repeat (settle) @(posedge clk);
        clear_counts();
        repeat (win) @(posedge clk);
        chk("sample_ticks", e_smp, n_smp);
        if (e_bit >= 0) chk("bit_ticks", e_bit, n_bit);
        if (e_chg >= 0) begin
            chk("data_change", e_chg, n_chg);
            chk("pin_rises", e_chg, n_rise);
            chk("change_off_rise", 0, n_mis);
        end
        $display("rate test done");
    endtask

    task automatic test_slave();
        int k;
        set_cfg(UBCG_PM_SYNC_SLAVE, 1'h0, 12'h000, 4'h0);
        // Wait until the last driven pin level has left the synchroniser, so
        // that the hand-over from the internal clock makes no stray edge.
        repeat (8) @(posedge clk);
        clear_counts();
        lk_n <= 8'h08;
        lk_start <= 1'b1;
        @(posedge clk);
        lk_start <= 1'b0;
        k = 0;
        while (lk_busy === 1'b1 && k < 400) begin
            @(posedge clk);
            k++;
        end
        if (k >= 400) begin
            failures++;
            report_and_stop();
        end
        repeat (8) @(posedge clk);
        chk("slave_change", 8, n_chg);
        chk("slave_sample", 8, n_dsm);
        chk("slave_oe", 0, pin_oe);
        $display("test_slave done");
    endtask

    initial begin
        rst_n = 1'b0;
        cfg = '0;
        lk_start = 1'b0;
        lk_n = 8'h00;
        pin_prev = 1'b0;
        chg_prev = 1'b0;
        failures = 0;
        compares = 0;
        clear_counts();
        repeat (5) @(posedge clk);
        chk("reset_spb", UBCG_SAMPLES_NORMAL, spb_q);
        chk("reset_framing", 1, framing_q);
        rst_n <= 1'b1;
        test_modes();
        rate(UBCG_PM_ASYNC, 1'h0, 12'h000, 4'h0, 20, 64, 64, 4, -1);
        rate(UBCG_PM_ASYNC, 1'h1, 12'h000, 4'h0, 20, 64, 64, 8, -1);
        rate(UBCG_PM_ASYNC, 1'h0, 12'h003, 4'h0, 20, 256, 64, 4, -1);
        rate(UBCG_PM_ASYNC, 1'h0, 12'h001, 4'h1, 20, 256, 64, 4, -1);
        rate(UBCG_PM_ASYNC, 1'h0, 12'h005, 4'hf, 20, 224, 64, 4, -1);
        rate(UBCG_PM_ASYNC, 1'h1, 12'h07f, 4'h0, 300, 2048, 16, 2, -1);
        rate(UBCG_PM_ASYNC, 1'h0, 12'hfff, 4'h0, 300, 8192, 2, -1, -1);
        rate(UBCG_PM_SYNC_MASTER, 1'h0, 12'h002, 4'h3, 4200, 60, 10, 10, 10);
        rate(UBCG_PM_SPI_MASTER, 1'h0, 12'h000, 4'h0, 20, 64, 32, 32, 32);
        test_slave();
        report_and_stop();
    end
endmodule
`default_nettype wire

//--- ubcg_core.sv
/*
 Baud clock generator for a serial port in asynchronous, synchronous or
 master SPI operation. Drives sampling and bit ticks to the shift logic.
 Assumes configuration comes from logic on clk; the transfer clock pin is
 asynchronous and is synchronised here.
*/
`default_nettype none
module ubcg_core
    import ubcg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire ubcg_cfg_t cfg,
    input wire logic transfer_clock_pin_i,
    output logic transfer_clock_pin_o,
    output logic transfer_clock_pin_oe,
    output ubcg_ticks_t ticks_q,
    output logic framing_enable_q,
    output logic [4:0] samples_per_bit_q,
    output ubcg_clock_mode_t clock_mode_q
);
    ubcg_clock_mode_t mode_d;
    logic gen_enable;
    logic gen_use_scale;
    logic gen_tick;
    logic pin_meta_q;
    logic pin_sync_q;
    logic pin_last_q;
    logic pin_rise;
    logic pin_fall;
    logic [3:0] sample_cnt_q;
    logic [3:0] sample_last;
    logic is_async;
    logic is_int_sync;
    logic int_clk_q;

    // ------------------------------------------------------------------
    // Clock mode decode
    // ------------------------------------------------------------------
    always_comb begin
        case (cfg.port_mode)
            UBCG_PM_ASYNC: begin
                mode_d = cfg.double_speed_select ? UBCG_CM_ASYNC_DOUBLE
                                                 : UBCG_CM_ASYNC_NORMAL;
            end
            UBCG_PM_SYNC_MASTER: begin
                mode_d = UBCG_CM_SYNC_MASTER;
            end
            UBCG_PM_SYNC_SLAVE: begin
                mode_d = UBCG_CM_SYNC_SLAVE;
            end
            UBCG_PM_SPI_MASTER: begin
                mode_d = UBCG_CM_SPI_MASTER;
            end
            default: begin
                mode_d = UBCG_CM_ASYNC_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_mode_q <= UBCG_CM_ASYNC_NORMAL;
        end else begin
            clock_mode_q <= mode_d;
        end
    end

    always_comb begin
        is_async = (clock_mode_q == UBCG_CM_ASYNC_NORMAL)
                || (clock_mode_q == UBCG_CM_ASYNC_DOUBLE);
        is_int_sync = (clock_mode_q == UBCG_CM_SYNC_MASTER)
                   || (clock_mode_q == UBCG_CM_SPI_MASTER);
        gen_enable = clock_mode_q != UBCG_CM_SYNC_SLAVE;
        // Synchronous rates take no scale; only the async modes apply it.
        gen_use_scale = is_async;
        sample_last = (clock_mode_q == UBCG_CM_ASYNC_DOUBLE)
                    ? 4'(UBCG_SAMPLES_DOUBLE - 5'h01)
                    : 4'(UBCG_SAMPLES_NORMAL - 5'h01);
        pin_rise = pin_sync_q && !pin_last_q;
        pin_fall = !pin_sync_q && pin_last_q;
    end

    // ------------------------------------------------------------------
    // Fractional divider
    // ------------------------------------------------------------------
    ubcg_frac_div u_div (
        .clk(clk),
        .rst_n(rst_n),
        .enable(gen_enable),
        .use_scale(gen_use_scale),
        .period(cfg.baud_period_setting),
        .scale(cfg.baud_scale_exponent),
        .tick_q(gen_tick)
    );

    // ------------------------------------------------------------------
    // Transfer clock pin synchroniser
    // ------------------------------------------------------------------
    // The pin must hold each level for two clk periods; a faster or very
    // lopsided clock loses edges here.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
            pin_last_q <= 1'b0;
        end else begin
            pin_meta_q <= transfer_clock_pin_i;
            pin_sync_q <= pin_meta_q;
            pin_last_q <= pin_sync_q;
        end
    end

    // ------------------------------------------------------------------
    // Asynchronous sample counter
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_cnt_q <= 4'h0;
        end else if (!is_async) begin
            sample_cnt_q <= 4'h0;
        end else if (gen_tick) begin
            sample_cnt_q <= (sample_cnt_q >= sample_last) ? 4'h0 : sample_cnt_q + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Internal synchronous clock
    // ------------------------------------------------------------------
    // Each divider tick is half a bit, so the bit rate is half the tick rate.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_clk_q <= 1'b0;
        end else if (!is_int_sync) begin
            int_clk_q <= 1'b0;
        end else if (gen_tick) begin
            int_clk_q <= !int_clk_q;
        end
    end

    // ------------------------------------------------------------------
    // Output ticks
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ticks_q <= '0;
        end else begin
            ticks_q.sample_tick <= (is_async && gen_tick)
                                || (clock_mode_q == UBCG_CM_SYNC_SLAVE && pin_fall)
                                || (is_int_sync && gen_tick && int_clk_q);
            ticks_q.bit_tick <= (is_async && gen_tick && sample_cnt_q >= sample_last)
                             || (clock_mode_q == UBCG_CM_SYNC_SLAVE && pin_fall)
                             || (is_int_sync && gen_tick && int_clk_q);
            ticks_q.data_change <= (clock_mode_q == UBCG_CM_SYNC_SLAVE && pin_rise)
                                || (is_int_sync && gen_tick && !int_clk_q);
            ticks_q.data_sample <= (clock_mode_q == UBCG_CM_SYNC_SLAVE && pin_fall)
                                || (is_int_sync && gen_tick && int_clk_q);
        end
    end

    // ------------------------------------------------------------------
    // Pin drive and mode status
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            transfer_clock_pin_o <= 1'b0;
            transfer_clock_pin_oe <= 1'b0;
        end else begin
            transfer_clock_pin_o <= int_clk_q;
            transfer_clock_pin_oe <= is_int_sync;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            framing_enable_q <= 1'b1;
            samples_per_bit_q <= UBCG_SAMPLES_NORMAL;
        end else begin
            // Buffers, shifters and divider stay live in SPI mode; only
            // the framing logic downstream is switched off.
            framing_enable_q <= clock_mode_q != UBCG_CM_SPI_MASTER;
            case (clock_mode_q)
                UBCG_CM_ASYNC_NORMAL: begin
                    samples_per_bit_q <= UBCG_SAMPLES_NORMAL;
                end
                UBCG_CM_ASYNC_DOUBLE: begin
                    samples_per_bit_q <= UBCG_SAMPLES_DOUBLE;
                end
                default: begin
                    samples_per_bit_q <= UBCG_SAMPLES_NONE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    slave_no_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
        clock_mode_q == UBCG_CM_SYNC_SLAVE ##1 clock_mode_q == UBCG_CM_SYNC_SLAVE
        |-> !transfer_clock_pin_oe && !gen_tick)
        else $error("slave mode drives the transfer clock");
    spi_framing_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        clock_mode_q == UBCG_CM_SPI_MASTER |=> !framing_enable_q)
        else $error("framing left on in SPI mode");
    double_samples_a: assert property (@(posedge clk) disable iff (!rst_n)
        clock_mode_q == UBCG_CM_ASYNC_DOUBLE |=> samples_per_bit_q == 5'h08)
        else $error("double speed not eight samples per bit");
    normal_samples_a: assert property (@(posedge clk) disable iff (!rst_n)
        clock_mode_q == UBCG_CM_ASYNC_NORMAL |=> samples_per_bit_q == 5'h10)
        else $error("normal speed not sixteen samples per bit");
    async_bit_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
        is_async && gen_tick && sample_cnt_q == sample_last |=> ticks_q.bit_tick)
        else $error("bit tick missing after last sample");
    async_no_early_a: assert property (@(posedge clk) disable iff (!rst_n)
        is_async && sample_cnt_q < sample_last |=> !ticks_q.bit_tick)
        else $error("bit tick before last sample");
    clk_on_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
        is_int_sync && $past(is_int_sync) && $changed(int_clk_q) |-> $past(gen_tick))
        else $error("transfer clock toggled without a divider tick");
    slave_sample_a: assert property (@(posedge clk) disable iff (!rst_n)
        clock_mode_q == UBCG_CM_SYNC_SLAVE && pin_fall
        |=> ticks_q.data_sample && ticks_q.bit_tick)
        else $error("slave falling edge not sampled");
    slave_change_a: assert property (@(posedge clk) disable iff (!rst_n)
        clock_mode_q == UBCG_CM_SYNC_SLAVE && pin_rise |=> ticks_q.data_change)
        else $error("slave rising edge not turned into a change");
    // The change tick and the pin register the internal clock one stage apart,
    // so the change always leads the pin's rise by one cycle.
    change_before_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
        is_int_sync && ticks_q.data_change |=> $rose(transfer_clock_pin_o))
        else $error("data change not followed by a transfer clock rise");

    async_bit_c: cover property (@(posedge clk) disable iff (!rst_n)
        clock_mode_q == UBCG_CM_ASYNC_NORMAL && ticks_q.bit_tick);
    double_bit_c: cover property (@(posedge clk) disable iff (!rst_n)
        clock_mode_q == UBCG_CM_ASYNC_DOUBLE && ticks_q.bit_tick);
    spi_clock_c: cover property (@(posedge clk) disable iff (!rst_n)
        clock_mode_q == UBCG_CM_SPI_MASTER && $rose(transfer_clock_pin_o));
    slave_bit_c: cover property (@(posedge clk) disable iff (!rst_n)
        clock_mode_q == UBCG_CM_SYNC_SLAVE && ticks_q.bit_tick);
endmodule
`default_nettype wire

//--- ubcg_core_end_marker_unused.sv
`default_nettype none
`default_nettype wire

//--- ubcg_frac_div.sv
/*
 Fractional rate divider: a down counter reloaded from the period setting,
 with the scale exponent stretching the count or adding fractional carries.
 Assumes period and scale come from logic on the same clock.
*/
`default_nettype none
module ubcg_frac_div
    import ubcg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic use_scale,
    input wire logic [11:0] period,
    input wire logic signed [3:0] scale,
    output logic tick_q
);
    logic [18:0] cnt_q;
    logic [6:0] acc_q;
    logic [2:0] mag;
    logic neg;
    logic [2:0] shift_pos;
    logic [19:0] len_pos;
    logic [18:0] reload_pos;
    logic [11:0] int_part;
    logic [11:0] frac_mask;
    logic [7:0] acc_sum;
    logic [7:0] modulus;
    logic wrap;
    logic [18:0] reload_neg;
    logic [6:0] acc_d;

    // --------------------------------------------------------------
    // Reload value
    // --------------------------------------------------------------
    always_comb begin
        mag = scale[3] ? 3'((~scale) + 4'h1) : scale[2:0];
        neg = use_scale && scale[3];
        shift_pos = (use_scale && !scale[3]) ? mag : 3'h0;
        // The full 12-bit setting is used, so 4095 scaled by 2^7 still fits.
        len_pos = ({8'h00, period} + 20'h00001) << shift_pos;
        reload_pos = 19'(len_pos - 20'h00001);
        // Negative exponent: integer part per tick plus a fractional carry.
        int_part = period >> mag;
        frac_mask = (12'h001 << mag) - 12'h001;
        acc_sum = {1'b0, acc_q} + {1'b0, period[6:0] & frac_mask[6:0]};
        modulus = 8'h01 << mag;
        wrap = acc_sum >= modulus;
        acc_d = wrap ? 7'(acc_sum - modulus) : acc_sum[6:0];
        reload_neg = {7'h00, int_part} + {18'h00000, wrap};
    end

    // --------------------------------------------------------------
    // Counter and tick
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 19'h00000;
            acc_q <= 7'h00;
            tick_q <= 1'b0;
        end else if (!enable) begin
            cnt_q <= 19'h00000;
            acc_q <= 7'h00;
            tick_q <= 1'b0;
        end else if (cnt_q == 19'h00000) begin
            tick_q <= 1'b1;
            cnt_q <= neg ? reload_neg : reload_pos;
            acc_q <= neg ? acc_d : 7'h00;
        end else begin
            tick_q <= 1'b0;
            cnt_q <= cnt_q - 19'h00001;
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    terminal_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
        enable && cnt_q == 19'h00000 |=> tick_q)
        else $error("divider missed its tick at terminal count");
    count_down_a: assert property (@(posedge clk) disable iff (!rst_n)
        enable && cnt_q != 19'h00000 |=> !tick_q && cnt_q == $past(cnt_q) - 19'h00001)
        else $error("divider count did not step down");
    neg_reload_a: assert property (@(posedge clk) disable iff (!rst_n)
        enable && neg && cnt_q == 19'h00000
        |=> cnt_q == {7'h00, $past(int_part)} || cnt_q == {7'h00, $past(int_part)} + 19'h1)
        else $error("negative exponent reload out of range");
endmodule
`default_nettype wire

//--- ubcg_pkg.sv
/*
 Shared constants, mode encodings and carrier structs for the serial port
 baud clock generator. Assumes a single peripheral clock domain.
*/
`default_nettype none
package ubcg_pkg;
    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int unsigned UBCG_PERIOD_W = 12;
    localparam int unsigned UBCG_SCALE_W = 4;
    localparam int unsigned UBCG_CNT_W = 19;
    localparam int unsigned UBCG_LEN_W = 20;
    localparam int unsigned UBCG_ACC_W = 7;
    localparam int unsigned UBCG_SPB_W = 5;
    localparam logic [4:0] UBCG_SAMPLES_NORMAL = 5'h10;
    localparam logic [4:0] UBCG_SAMPLES_DOUBLE = 5'h08;
    localparam logic [4:0] UBCG_SAMPLES_NONE = 5'h00;
    localparam logic [11:0] UBCG_PERIOD_RESET = 12'h000;
    localparam logic [3:0] UBCG_SCALE_RESET = 4'h0;

    // ------------------------------------------------------------------
    // Port modes chosen by software and the resulting clock modes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        UBCG_PM_ASYNC = 4'b0001,
        UBCG_PM_SYNC_MASTER = 4'b0010,
        UBCG_PM_SYNC_SLAVE = 4'b0100,
        UBCG_PM_SPI_MASTER = 4'b1000
    } ubcg_port_mode_t;

    typedef enum logic [4:0] {
        UBCG_CM_ASYNC_NORMAL = 5'b00001,
        UBCG_CM_ASYNC_DOUBLE = 5'b00010,
        UBCG_CM_SYNC_MASTER = 5'b00100,
        UBCG_CM_SYNC_SLAVE = 5'b01000,
        UBCG_CM_SPI_MASTER = 5'b10000
    } ubcg_clock_mode_t;

    typedef struct packed {
        ubcg_port_mode_t port_mode;
        logic double_speed_select;
        logic [11:0] baud_period_setting;
        logic signed [3:0] baud_scale_exponent;
    } ubcg_cfg_t;

    typedef struct packed {
        logic sample_tick;
        logic bit_tick;
        logic data_change;
        logic data_sample;
    } ubcg_ticks_t;
endpackage
`default_nettype wire

//--- ubcg_xck_model.sv
/*
 Far-side transfer clock source for synchronous slave runs.
 Assumes the bench starts it only while the block listens on the pin.
*/
`default_nettype none
module ubcg_link_clk_model (
    input wire logic start,
    input wire logic [7:0] n_pulses,
    output logic pin,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Burst generator
    // ------------------------------------------------------------------
    // The clock stands low between bursts, as a real master would leave it.
    // The 7 ns offset keeps its edges away from the block's clock edges.
    initial begin
        pin = 1'b0;
        busy = 1'b0;
    end

    always @(posedge start) begin
        busy = 1'b1;
        #7;
        repeat (n_pulses) begin
            pin = 1'b1;
            #80;
            pin = 1'b0;
            #80;
        end
        busy = 1'b0;
    end
endmodule
`default_nettype wire
